/* File: verilog/fbg_pkg.sv */
`default_nettype none
package fbg_pkg;
    // register offsets on the byte-wide parallel port
    localparam logic [3:0] ADDR_HOLD       = 4'h0;  // transmit holding register, write only
    localparam logic [3:0] ADDR_DIV_LOW    = 4'h1;  // divisor integer bits 7:0
    localparam logic [3:0] ADDR_DIV_HIGH   = 4'h2;  // divisor integer bits 15:8
    localparam logic [3:0] ADDR_DIV_FRAC   = 4'h3;  // divisor fraction, low nibble
    localparam logic [3:0] ADDR_LINE_CTRL  = 4'h4;  // frame format
    localparam logic [3:0] ADDR_LINE_STAT  = 4'h5;  // line status, read only
    localparam logic [3:0] ADDR_MODEM_CTRL = 4'h6;  // modem control, prescaler select
    localparam logic [3:0] ADDR_EIGHT_X    = 4'h7;  // 8x sampling select
    localparam logic [3:0] ADDR_FOUR_X     = 4'h8;  // 4x sampling select

    // reset values
    localparam logic [7:0] RST_DIV_LOW    = 8'h01;
    localparam logic [7:0] RST_DIV_HIGH   = 8'h00;
    localparam logic [7:0] RST_DIV_FRAC   = 8'h00;
    localparam logic [7:0] RST_LINE_CTRL  = 8'h03;  // 8 data bits, no parity, 1 stop
    localparam logic [7:0] RST_MODEM_CTRL = 8'h00;
    localparam logic [7:0] RST_SEL        = 8'h00;
    localparam logic [7:0] SEL_ON         = 8'hFF;  // value that turns a sampling select on

    // field positions
    localparam int MCR_PRESCALE_BIT = 7;  // 1 = divide input clock by 4
    localparam int LC_WLEN_LSB      = 0;  // 2 bits: 0..3 = 5..8 data bits
    localparam int LC_STOP2_BIT     = 2;  // 1 = two stop bits
    localparam int LC_PAR_EN_BIT    = 3;  // 1 = parity bit sent
    localparam int LC_PAR_EVEN_BIT  = 4;  // 1 = even parity
    localparam int LS_HOLD_EMPTY    = 5;  // transmit fifo empty
    localparam int LS_TX_EMPTY      = 6;  // fifo and shifter both empty
    localparam int FRAC_BITS        = 4;  // implemented fraction bits

    // timing counts
    localparam logic [1:0] PRESCALE_LAST = 2'h3;     // divide by 4: ticks on count 3
    localparam logic [4:0] SPB_16X       = 5'h10;
    localparam logic [4:0] SPB_8X        = 5'h08;
    localparam logic [4:0] SPB_4X        = 5'h04;
    localparam logic [3:0] MIN_DATA_BITS = 4'h5;

    // fifo shape
    localparam int TX_FIFO_WIDTH = 8;
    localparam int TX_FIFO_DEPTH = 16;

    // transmitter states
    typedef enum logic [4:0] {
        TX_IDLE   = 5'b00001,
        TX_START  = 5'b00010,
        TX_DATA   = 5'b00100,
        TX_PARITY = 5'b01000,
        TX_STOP   = 5'b10000
    } fbg_tx_state_type;
endpackage : fbg_pkg
`default_nettype wire

/* File: verilog/fbg_fifo_if.sv */
`timescale 1ns/100ps
`default_nettype none
// carries the fill and drain handshakes between transmitter and its fifo
interface fbg_fifo_if #(
    parameter int WIDTH = 8
);
    logic             wr_valid;  // byte offered for storage
    logic             wr_ready;  // fifo has room
    logic [WIDTH-1:0] wr_data;   // byte to store
    logic             rd_valid;  // fifo holds data
    logic             rd_ready;  // head taken this cycle
    logic [WIDTH-1:0] rd_data;   // head of fifo

    // side that fills and drains
    modport user (output wr_valid, output wr_data, input wr_ready,
                  input rd_valid, input rd_data, output rd_ready);
    // storage side
    modport store (input wr_valid, input wr_data, output wr_ready,
                   output rd_valid, output rd_data, input rd_ready);
endinterface : fbg_fifo_if
`default_nettype wire

/* File: verilog/fbg_fifo.sv */
`timescale 1ns/100ps
`default_nettype none
// first-in first-out store with valid/ready on both sides
module fbg_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input  wire logic clk,
    input  wire logic sys_rst,
    fbg_fifo_if.store port
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];   // storage array
    logic [AW:0]      wr_ptr_q;      // write pointer with wrap bit
    logic [AW:0]      rd_ptr_q;      // read pointer with wrap bit
    logic             full;          // no room left
    logic             empty;         // nothing stored

    assign empty = (wr_ptr_q == rd_ptr_q);
    assign full  = (wr_ptr_q[AW] != rd_ptr_q[AW]) && (wr_ptr_q[AW-1:0] == rd_ptr_q[AW-1:0]);

    assign port.wr_ready = !full;
    assign port.rd_valid = !empty;
    assign port.rd_data  = mem[rd_ptr_q[AW-1:0]];

    // write side stores and advances
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            wr_ptr_q <= '0;
        end else if (port.wr_valid && !full) begin
            wr_ptr_q <= wr_ptr_q + 1'b1;
        end
    end

    // array itself, no reset needed
    always_ff @(posedge clk) begin
        if (port.wr_valid && !full) begin
            mem[wr_ptr_q[AW-1:0]] <= port.wr_data;
        end
    end

    // read side advances on accepted pop
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rd_ptr_q <= '0;
        end else if (port.rd_ready && !empty) begin
            rd_ptr_q <= rd_ptr_q + 1'b1;
        end
    end
endmodule : fbg_fifo
`default_nettype wire

/* File: verilog/fbg_channel.sv */
`timescale 1ns/100ps
`default_nettype none
// Operation
// - one oscillator clock drives every channel generator
// - each channel owns generator and prescaler
// - prescaler bit divides by one or four
// - divisor one to 65536 minus one sixteenth
// - sampling tick times transmit shifting, receive sampling
// - divisor resets to one
// - high byte bits 15:8, low 7:0
// - four fraction bits add n sixteenths
// - 8x or 4x when that select alone is 0xFF, else 16x (both at 0xFF gives 16x)
// - 8x odd fraction may jitter one sixteenth
// - 8-bit shifter fed from 16-byte fifo
// - bit lasts 16, 8 or 4 ticks
// - start, data, optional parity, stop bits
// - fifo and shifter status in line status
// - holding empty set when fifo empty
// - transmitter empty when fifo and shifter empty
// - least significant data bit sent first
module fbg_channel (
    input  wire logic       clk,              // oscillator clock, shared by all channels
    input  wire logic       sys_rst,          // asynchronous reset, active high
    input  wire logic       cs_n,             // chip select, active low
    input  wire logic       wr_en,            // one-cycle write strobe
    input  wire logic       rd_en,            // one-cycle read strobe
    input  wire logic [3:0] addr,             // register offset
    input  wire logic [7:0] wdata,            // write data
    output logic      [7:0] rdata,            // read data, registered
    output logic            tx_fifo_ready,    // transmit fifo can take a byte
    output logic            sample_tick,      // sampling clock enable, also for the receiver
    output logic            tx_out            // serial output, idles high
);
    // local sampling-mode decode used by the shifter bit timing
    function automatic logic [4:0] samples_per_bit(input logic [7:0] eight_sel,
                                                   input logic [7:0] four_sel);
        logic e8;
        logic e4;
        e8 = (eight_sel == fbg_pkg::SEL_ON);
        e4 = (four_sel == fbg_pkg::SEL_ON);
        if (e8 && !e4) begin
            samples_per_bit = fbg_pkg::SPB_8X;
        end else if (e4 && !e8) begin
            samples_per_bit = fbg_pkg::SPB_4X;
        end else begin
            samples_per_bit = fbg_pkg::SPB_16X;   // both off, or reserved both-on
        end
    endfunction : samples_per_bit

    // register access decode
    function automatic logic hit(input logic cs_n_i, input logic strobe,
                                 input logic [3:0] a, input logic [3:0] target);
        hit = !cs_n_i && strobe && (a == target);
    endfunction : hit

    logic [7:0]  divisor_low_byte_q;        // integer bits 7:0
    logic [7:0]  divisor_high_byte_q;       // integer bits 15:8
    logic [7:0]  divisor_fraction_q;        // fraction, low nibble used
    logic [7:0]  line_ctrl_q;               // frame format
    logic [7:0]  modem_control_reg_q;       // prescaler select in bit 7
    logic [7:0]  eight_x_sampling_select_q; // 8x select
    logic [7:0]  four_x_sampling_select_q;  // 4x select
    logic [7:0]  line_status_reg;           // assembled status
    logic [7:0]  rdata_q;                   // read data register
    logic [1:0]  pre_cnt_q;                 // prescaler counter
    logic        pre_tick;                  // prescaled clock enable
    logic [16:0] div_cnt_q;                 // remaining prescaled ticks in period
    logic [3:0]  frac_acc_q;                // fraction accumulator
    logic [4:0]  frac_sum;                  // accumulator plus fraction, carry on top
    logic [16:0] int_eff;                   // integer divisor, zero taken as one
    logic [16:0] next_period;               // length of next sampling period
    logic        tick;                      // sampling clock enable, internal
    logic        sample_tick_q;             // registered copy for the port
    fbg_pkg::fbg_tx_state_type state_q;     // transmitter state
    logic [7:0]  shift_q;                   // transmit shift register
    logic [4:0]  smp_q;                     // sampling ticks within a bit
    logic [3:0]  bitn_q;                    // data bits sent
    logic        stopn_q;                   // first stop bit done
    logic        par_q;                     // parity of loaded byte
    logic        tx_q;                      // serial line register
    logic [4:0]  spb;                       // ticks per bit
    logic        bit_end;                   // last tick of current bit
    logic [3:0]  nbits;                     // data bits per frame
    logic        fifo_empty;                // nothing queued
    logic        shifter_idle;              // no frame in flight

    fbg_fifo_if #(.WIDTH(fbg_pkg::TX_FIFO_WIDTH)) txq ();

    // transmit fifo in front of the shifter
    fbg_fifo #(
        .WIDTH (fbg_pkg::TX_FIFO_WIDTH),
        .DEPTH (fbg_pkg::TX_FIFO_DEPTH)
    ) u_tx_fifo (
        .clk     (clk),
        .sys_rst (sys_rst),
        .port    (txq.store)
    );

    // holding register writes go straight into the fifo
    assign txq.wr_valid = hit(cs_n, wr_en, addr, fbg_pkg::ADDR_HOLD);
    assign txq.wr_data  = wdata;
    assign tx_fifo_ready = txq.wr_ready;

    // configuration registers
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            divisor_low_byte_q        <= fbg_pkg::RST_DIV_LOW;
            divisor_high_byte_q       <= fbg_pkg::RST_DIV_HIGH;
            divisor_fraction_q        <= fbg_pkg::RST_DIV_FRAC;
            line_ctrl_q               <= fbg_pkg::RST_LINE_CTRL;
            modem_control_reg_q       <= fbg_pkg::RST_MODEM_CTRL;
            eight_x_sampling_select_q <= fbg_pkg::RST_SEL;
            four_x_sampling_select_q  <= fbg_pkg::RST_SEL;
        end else begin
            if (hit(cs_n, wr_en, addr, fbg_pkg::ADDR_DIV_LOW)) begin
                divisor_low_byte_q <= wdata;
            end
            if (hit(cs_n, wr_en, addr, fbg_pkg::ADDR_DIV_HIGH)) begin
                divisor_high_byte_q <= wdata;
            end
            if (hit(cs_n, wr_en, addr, fbg_pkg::ADDR_DIV_FRAC)) begin
                // upper nibble not implemented
                divisor_fraction_q <= {4'h0, wdata[fbg_pkg::FRAC_BITS-1:0]};
            end
            if (hit(cs_n, wr_en, addr, fbg_pkg::ADDR_LINE_CTRL)) begin
                line_ctrl_q <= wdata;
            end
            if (hit(cs_n, wr_en, addr, fbg_pkg::ADDR_MODEM_CTRL)) begin
                modem_control_reg_q <= wdata;
            end
            if (hit(cs_n, wr_en, addr, fbg_pkg::ADDR_EIGHT_X)) begin
                eight_x_sampling_select_q <= wdata;
            end
            if (hit(cs_n, wr_en, addr, fbg_pkg::ADDR_FOUR_X)) begin
                four_x_sampling_select_q <= wdata;
            end
        end
    end

    // status: fifo empty and whole transmitter empty
    assign fifo_empty   = !txq.rd_valid;
    assign shifter_idle = (state_q == fbg_pkg::TX_IDLE);
    always_comb begin
        line_status_reg = 8'h00;
        line_status_reg[fbg_pkg::LS_HOLD_EMPTY] = fifo_empty;
        line_status_reg[fbg_pkg::LS_TX_EMPTY]   = fifo_empty && shifter_idle;
    end

    // read data, one cycle after the strobe; unmapped reads give zero
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rdata_q <= 8'h00;
        end else if (!cs_n && rd_en) begin
            case (addr)
                fbg_pkg::ADDR_DIV_LOW:    rdata_q <= divisor_low_byte_q;
                fbg_pkg::ADDR_DIV_HIGH:   rdata_q <= divisor_high_byte_q;
                fbg_pkg::ADDR_DIV_FRAC:   rdata_q <= divisor_fraction_q;
                fbg_pkg::ADDR_LINE_CTRL:  rdata_q <= line_ctrl_q;
                fbg_pkg::ADDR_LINE_STAT:  rdata_q <= line_status_reg;
                fbg_pkg::ADDR_MODEM_CTRL: rdata_q <= modem_control_reg_q;
                fbg_pkg::ADDR_EIGHT_X:    rdata_q <= eight_x_sampling_select_q;
                fbg_pkg::ADDR_FOUR_X:     rdata_q <= four_x_sampling_select_q;
                default:                  rdata_q <= 8'h00;
            endcase
        end
    end
    assign rdata = rdata_q;

    // prescaler: every clock, or every fourth clock when selected
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pre_cnt_q <= 2'h0;
        end else begin
            pre_cnt_q <= pre_cnt_q + 2'h1;
        end
    end
    assign pre_tick = modem_control_reg_q[fbg_pkg::MCR_PRESCALE_BIT] ?
                      (pre_cnt_q == fbg_pkg::PRESCALE_LAST) : 1'b1;

    // next period from the live registers, sampled only at reload
    assign int_eff     = ({divisor_high_byte_q, divisor_low_byte_q} == 16'h0000) ?
                         17'h00001 : {1'b0, divisor_high_byte_q, divisor_low_byte_q};
    assign frac_sum    = {1'b0, frac_acc_q} + {1'b0, divisor_fraction_q[3:0]};
    assign next_period = int_eff + {16'h0000, frac_sum[4]};
    assign tick        = pre_tick && (div_cnt_q <= 17'h00001);

    // divisor counter; a carry stretches one period by a prescaled tick
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            div_cnt_q  <= 17'h00001;
            frac_acc_q <= 4'h0;
        end else if (tick) begin
            div_cnt_q  <= next_period;
            frac_acc_q <= frac_sum[3:0];
        end else if (pre_tick) begin
            div_cnt_q <= div_cnt_q - 17'h00001;
        end
    end

    // registered sampling enable for the receiver side
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            sample_tick_q <= 1'b0;
        end else begin
            sample_tick_q <= tick;
        end
    end
    assign sample_tick = sample_tick_q;

    // bit timing in sampling ticks; odd fractions at 8x give uneven bits
    assign spb     = samples_per_bit(eight_x_sampling_select_q, four_x_sampling_select_q);
    assign bit_end = tick && (smp_q == spb - 5'h01);
    assign nbits   = fbg_pkg::MIN_DATA_BITS +
                     {2'b00, line_ctrl_q[fbg_pkg::LC_WLEN_LSB +: 2]};

    // pop the fifo head when the shifter is free
    assign txq.rd_ready = shifter_idle && txq.rd_valid;

    // sampling tick count inside a bit
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            smp_q <= 5'h00;
        end else if (shifter_idle) begin
            smp_q <= 5'h00;
        end else if (bit_end) begin
            smp_q <= 5'h00;
        end else if (tick) begin
            smp_q <= smp_q + 5'h01;
        end
    end

    // frame sequencer
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_q <= fbg_pkg::TX_IDLE;
            shift_q <= 8'h00;
            bitn_q  <= 4'h0;
            stopn_q <= 1'b0;
            par_q   <= 1'b0;
            tx_q    <= 1'b1;
        end else begin
            case (state_q)
                fbg_pkg::TX_IDLE: begin
                    // load a byte and drive the start bit at once
                    if (txq.rd_valid) begin
                        shift_q <= txq.rd_data;
                        par_q   <= ^(txq.rd_data & (8'hFF >> (4'h8 - nbits))) ^
                                   !line_ctrl_q[fbg_pkg::LC_PAR_EVEN_BIT];
                        tx_q    <= 1'b0;
                        state_q <= fbg_pkg::TX_START;
                    end else begin
                        tx_q <= 1'b1;
                    end
                end
                fbg_pkg::TX_START: begin
                    // first data bit is bit 0
                    if (bit_end) begin
                        tx_q    <= shift_q[0];
                        shift_q <= {1'b0, shift_q[7:1]};
                        bitn_q  <= 4'h1;
                        state_q <= fbg_pkg::TX_DATA;
                    end
                end
                fbg_pkg::TX_DATA: begin
                    if (bit_end) begin
                        if (bitn_q == nbits) begin
                            // data done: parity if enabled, else stop
                            stopn_q <= 1'b0;
                            if (line_ctrl_q[fbg_pkg::LC_PAR_EN_BIT]) begin
                                tx_q    <= par_q;
                                state_q <= fbg_pkg::TX_PARITY;
                            end else begin
                                tx_q    <= 1'b1;
                                state_q <= fbg_pkg::TX_STOP;
                            end
                        end else begin
                            tx_q    <= shift_q[0];
                            shift_q <= {1'b0, shift_q[7:1]};
                            bitn_q  <= bitn_q + 4'h1;
                        end
                    end
                end
                fbg_pkg::TX_PARITY: begin
                    if (bit_end) begin
                        tx_q    <= 1'b1;
                        state_q <= fbg_pkg::TX_STOP;
                    end
                end
                fbg_pkg::TX_STOP: begin
                    // one or two stop bits, line stays high
                    if (bit_end) begin
                        if (line_ctrl_q[fbg_pkg::LC_STOP2_BIT] && !stopn_q) begin
                            stopn_q <= 1'b1;
                        end else begin
                            state_q <= fbg_pkg::TX_IDLE;
                        end
                    end
                end
                default: begin
                    state_q <= fbg_pkg::TX_IDLE;
                    tx_q    <= 1'b1;
                end
            endcase
        end
    end
    assign tx_out = tx_q;
endmodule : fbg_channel
`default_nettype wire

/* File: bench/fbg_channel_assertions.sv */
`timescale 1ns/100ps
`default_nettype none
// watches the channel ports only
module fbg_channel_checker (
    input wire logic       clk,
    input wire logic       sys_rst,
    input wire logic       cs_n,
    input wire logic       wr_en,
    input wire logic       rd_en,
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    input wire logic [7:0] rdata,
    input wire logic       tx_fifo_ready,
    input wire logic       sample_tick,
    input wire logic       tx_out
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);
    wire logic rd_go = !cs_n && rd_en;  // a read taken this edge
    wire logic st_rd = rd_go && (addr == fbg_pkg::ADDR_LINE_STAT);  // status read

    property p_rst_idle;
        $fell(sys_rst) |-> tx_out && !sample_tick && tx_fifo_ready && (rdata == 8'h00);
    endproperty
    a_rst_idle: assert property (p_rst_idle) else $error("outputs not idle after reset");
    property p_null_read;
        rd_go && (addr == fbg_pkg::ADDR_HOLD) |=> rdata == 8'h00;
    endproperty
    a_null_read: assert property (p_null_read) else $error("holding read not zero");
    property p_frac_read;
        rd_go && (addr == fbg_pkg::ADDR_DIV_FRAC) |=> rdata[7:4] == 4'h0;
    endproperty
    a_frac_read: assert property (p_frac_read) else $error("fraction upper bits set");
    property p_rdata_hold;
        !rd_go |=> $stable(rdata);
    endproperty
    a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
    property p_start_len;
        $fell(tx_out) |-> (!tx_out) [*4];
    endproperty
    a_start_len: assert property (p_start_len) else $error("low bit too short");
    property p_bit_len;
        $rose(tx_out) |-> ##1 tx_out [*3];
    endproperty
    a_bit_len: assert property (p_bit_len) else $error("high bit too short");
    property p_full_busy;
        st_rd && !tx_fifo_ready |=> !rdata[fbg_pkg::LS_HOLD_EMPTY] && !rdata[fbg_pkg::LS_TX_EMPTY];
    endproperty
    a_full_busy: assert property (p_full_busy) else $error("full fifo shown empty");
    property p_line_busy;
        st_rd && !tx_out |=> !rdata[fbg_pkg::LS_TX_EMPTY];
    endproperty
    a_line_busy: assert property (p_line_busy) else $error("busy shifter shown empty");
    c_full: cover property (!tx_fifo_ready);
    c_frame: cover property ($fell(tx_out));
    c_status: cover property (st_rd && !tx_out);
endmodule : fbg_channel_checker
bind fbg_channel fbg_channel_checker u_fbg_channel_checker (.clk(clk), .sys_rst(sys_rst),
    .cs_n(cs_n), .wr_en(wr_en), .rd_en(rd_en), .addr(addr), .wdata(wdata), .rdata(rdata),
    .tx_fifo_ready(tx_fifo_ready), .sample_tick(sample_tick), .tx_out(tx_out));
`default_nettype wire

/* File: bench/fbg_serial_sink.sv */
`timescale 1ns/100ps
`default_nettype none
// remote receiver: times bit 0 of each frame, then samples mid-bit
module fbg_serial_sink (
    input  wire logic       clk,
    input  wire logic       line,
    output var  int         bit_len,
    output logic      [9:0] samp,
    output var  int         frames
);
    int t;  // clocks counted in a level
    // count clocks until the line reaches a level
    task automatic run_to(input logic lvl, output int cnt);
        cnt = 0;
        while (line !== lvl) begin
            @(posedge clk);
            #1;
            cnt++;
        end
    endtask : run_to
    initial begin
        bit_len = 0;
        samp = 10'h000;
        frames = 0;
    end
    // frames are expected to carry bit 0 high and bit 1 low
    always begin
        @(negedge line);
        run_to(1'b1, t);
        run_to(1'b0, t);
        bit_len = t;
        samp[1:0] = 2'b10;
        repeat (bit_len / 2) @(posedge clk);
        samp[2] = line;
        for (int k = 3; k < 10; k++) begin
            repeat (bit_len) @(posedge clk);
            samp[k] = line;
        end
        frames++;
    end
endmodule : fbg_serial_sink
`default_nettype wire

/* File: bench/fbg_channel_bench.sv */
`timescale 1ns/100ps
`default_nettype none
module fbg_channel_bench;
    logic       clk, sys_rst, cs_n, wr_en, rd_en, tx_fifo_ready, sample_tick, tx_out;
    logic [3:0] addr;
    logic [7:0] wdata, rdata, v;
    logic [9:0] samp;
    int         err_count, cmp_count, bit_len, frames, n;
    logic [7:0] rst_tab [9] = '{8'h00, 8'h01, 8'h00, 8'h00, 8'h03, 8'h00, 8'h00, 8'h00, 8'h00};
    fbg_channel u_fbg_channel (.clk(clk), .sys_rst(sys_rst), .cs_n(cs_n), .wr_en(wr_en),
        .rd_en(rd_en), .addr(addr), .wdata(wdata), .rdata(rdata),
        .tx_fifo_ready(tx_fifo_ready), .sample_tick(sample_tick), .tx_out(tx_out));
    fbg_serial_sink u_fbg_serial_sink (.clk(clk), .line(tx_out), .bit_len(bit_len),
        .samp(samp), .frames(frames));
    always #2 clk = ~clk;
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic conclude();
        $display("counts: %0d compares, %0d mismatches", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : conclude
    // one register write, driven on falling edges
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(negedge clk);
        {cs_n, wr_en, addr, wdata} = {2'b01, a, d};
        @(negedge clk);
        {cs_n, wr_en} = 2'b10;
    endtask : wr
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(negedge clk);
        {cs_n, rd_en, addr} = {2'b01, a};
        @(negedge clk);
        {cs_n, rd_en} = 2'b10;
        d = rdata;
    endtask : rd
    // expected line levels: start, data lsb first, parity, stop
    function automatic logic [9:0] efr(input logic [7:0] lc, input logic [7:0] b);
        int nb = int'(lc[1:0]) + 5;
        logic [9:0] f = 10'h3FE;
        for (int k = 0; k < nb; k++) f[k+1] = b[k];
        if (lc[3]) f[nb+1] = lc[4] ^ ^(b & 8'((9'h001 << nb) - 1)) ^ 1'b1 ^ 1'b1 ^ !lc[4] ^ lc[4];
        return f;
    endfunction : efr
    task automatic regs();
        for (int a = 1; a < 10; a++) begin
            rd(4'(a), v);
            if (a != 5) check(16'(v), 16'(a < 9 ? rst_tab[a] : 8'h00));
        end
        check(16'(tx_fifo_ready), 16'h0001);
        check(16'(sample_tick), 16'h0001);
        rd(fbg_pkg::ADDR_LINE_STAT, v);
        check(16'(v & 8'h60), 16'h0060);
        wr(fbg_pkg::ADDR_DIV_FRAC, 8'hFF);
        rd(fbg_pkg::ADDR_DIV_FRAC, v);
        check(16'(v), 16'h000F);
        wr(fbg_pkg::ADDR_DIV_HIGH, 8'h01);
        rd(fbg_pkg::ADDR_DIV_HIGH, v);
        check(16'(v), 16'h0001);
        $display("register test done");
    endtask : regs
    // program a setting, send one byte, judge bit length and frame
    task automatic frame(input logic [7:0] lc, md, e8, f4, lo, hi, fr, b, input int len);
        int f0;
        wr(fbg_pkg::ADDR_LINE_CTRL, lc);
        wr(fbg_pkg::ADDR_MODEM_CTRL, md);
        wr(fbg_pkg::ADDR_EIGHT_X, e8);
        wr(fbg_pkg::ADDR_FOUR_X, f4);
        wr(fbg_pkg::ADDR_DIV_LOW, lo);
        wr(fbg_pkg::ADDR_DIV_HIGH, hi);
        wr(fbg_pkg::ADDR_DIV_FRAC, fr);
        f0 = frames;
        wr(fbg_pkg::ADDR_HOLD, b);
        for (n = 0; frames == f0 && n < 40000; n++) @(negedge clk);
        check(16'(bit_len), 16'(len));
        check(16'(samp), 16'(efr(lc, b)));
        repeat (len) @(negedge clk);
        $display("frame test done, bit length %0d", len);
    endtask : frame
    task automatic fill_drain();
        int k;
        int f0;
        f0 = frames;
        for (k = 0; tx_fifo_ready === 1'b1 && k < 40; k++) wr(fbg_pkg::ADDR_HOLD, 8'hC5);
        check(16'(k), 16'h0011);
        rd(fbg_pkg::ADDR_LINE_STAT, v);
        check(16'(v & 8'h60), 16'h0000);
        for (n = 0; frames - f0 < 17 && n < 9000; n++) @(negedge clk);
        repeat (40) @(negedge clk);
        check(16'(frames - f0), 16'h0011);
        check(16'(samp), 16'(efr(8'h0B, 8'hC5)));
        rd(fbg_pkg::ADDR_LINE_STAT, v);
        check(16'(v & 8'h60), 16'h0060);
        $display("fifo test done");
    endtask : fill_drain
    initial begin
        {clk, sys_rst, cs_n, wr_en, rd_en, addr, wdata} = {3'b011, 2'b00, 4'h0, 8'h00};
        {err_count, cmp_count} = {32'd0, 32'd0};
        repeat (16) @(negedge clk);
        sys_rst = 1'b0;
        regs();
        frame(8'h03, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'hC5, 16);
        frame(8'h03, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h08, 8'hC5, 24);
        frame(8'h03, 8'h80, 8'hFF, 8'h00, 8'h03, 8'h00, 8'h00, 8'hC5, 96);
        frame(8'h03, 8'h00, 8'h00, 8'hFF, 8'h00, 8'h01, 8'h00, 8'hC5, 1024);
        frame(8'h03, 8'h00, 8'hFF, 8'hFF, 8'h01, 8'h00, 8'h00, 8'hC5, 16);
        frame(8'h03, 8'h00, 8'hFF, 8'h00, 8'h01, 8'h00, 8'h02, 8'hC5, 9);
        frame(8'h1E, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h45, 16);
        frame(8'h0B, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h45, 16);
        fill_drain();
        sys_rst = 1'b1;
        repeat (16) @(negedge clk);
        sys_rst = 1'b0;
        rd(fbg_pkg::ADDR_LINE_CTRL, v);
        check(16'(v), 16'h0003);
        conclude();
    end
    // watchdog: the whole run needs about 16,000 clocks
    initial begin
        #200000;
        err_count++;
        conclude();
    end
endmodule : fbg_channel_bench
`default_nettype wire
